// >>> rtl/drc_top.sv
// Summary of operation
// RL1: byte, halfword and word accesses; each byte of a 16-bit register writable alone
// RL2: 8-bit registers below index 8, sample at 8, buffer at 0xC, 3/9/A/B reserved
// RL3: reserved bits read zero; software writes them as zero
// RL4: lockable registers ignore writes while the access protector locks them
// RL5: keep-in-standby low turns output buffer off in standby
// RL6: keep-in-standby acts at once without synchronisation
// RL7: enable reads back at once, sets pending, acts when synchronisation ends
// RL8: soft reset one returns all registers to reset and disables; zero ignored
// RL9: a write setting soft reset discards its other bits
// RL10: soft reset reads one until done; it and pending clear together
// RL11: reference select 0 internal 1V, 1 supply, 2 external, 3 reserved
// RL12: bypass bit lets buffer writes through despite protector lock
// RL13: pump disable low means automatic pump, high forces it off
// RL14: left justify picks upper ten bits, else lower ten bits
// RL15: internal output enable routes converter to comparator
// RL16: external output enable turns on the high-drive pin buffer
// RL17: empty event output enable emits an event when the buffer empties
// RL18: start event input enable moves buffer to sample and converts
// RL19: mask-clear write one disables an interrupt; same state seen in mask-set
// RL20: mask-set write one enables an interrupt; zero does nothing
// RL21: empty flag sets on buffer move, clears on write one or buffer write
// RL22: starved flag sets on start event with empty buffer; write one clears
// RL23: sync-done flag sets when pending falls, except after enable or soft reset
// RL24: interrupt output high while any flag and its enable are both set
// RL25: both mask registers read the one shared three-bit enable vector
`timescale 1ns/1ps
`default_nettype none

module drc_top #(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              I_REF_CLK,
	input  wire logic              I_ARST_N,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	input  wire logic [3:0]        I_PSTRB,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic              I_PROT_LOCK,
	input  wire logic              I_STANDBY,
	input  wire logic              I_START_EV,
	output logic                   O_EMPTY_EV,
	output logic                   O_DMA_REQ,
	output logic                   O_IRQ,
	output logic                   O_CONV_EN,
	output logic                   O_CONV_LOAD,
	output logic      [9:0]        O_DAC_CODE,
	output logic      [1:0]        O_REF_SEL,
	output logic                   O_PUMP_OFF,
	output logic                   O_INT_OUT_EN,
	output logic                   O_EXT_OUT_EN,
	output logic                   O_OUT_BUF_ON
);

	//------------------------------------------------------------
	// elaboration checks
	//------------------------------------------------------------
	// index 0xC sits at byte 0x30, so six address bits are the least
	if (ADDR_W < 6) begin : g_addr_check
		$error("ADDR_W must be at least 6");
	end

	//------------------------------------------------------------
	// helper functions
	//------------------------------------------------------------
	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// ten-bit code out of a sample word
	function automatic logic [9:0] code_of(input logic [15:0] v, input logic lj);
		code_of = lj ? v[15:6] : v[9:0]; // [RL14]
	endfunction : code_of

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic                      enable_r;
	logic                      stby_r;
	logic                      srst_r;
	drc_pkg::drc_outcfg_t      outcfg_r;
	logic [1:0]                evcfg_r;
	logic [2:0]                mask_r;
	logic [2:0]                flags_r;
	logic [15:0]               sample_r;
	logic [15:0]               buf_r;
	logic                      buf_empty_r;
	// converter-side copy of the enable
	logic                      en_eff_r;
	logic [9:0]                code_r;
	logic                      load_r;
	logic                      empty_ev_r;
	// cause_ctrl_r: window opened by enable or soft reset
	logic                      pend_r;
	logic                      cause_ctrl_r;
	logic [7:0]                sync_cnt_r;

	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------
	wire logic [3:0] idx        = I_PADDR[5:2];
	wire logic       upper_zero = (ADDR_W > 6) ? (I_PADDR >> 6) == '0 : 1'b1;
	wire logic       mapped     = (idx <= drc_pkg::IDX_SAMPLE && idx != drc_pkg::IDX_RSV3) ||
	                              idx == drc_pkg::IDX_BUF; // [RL2]
	wire logic       addr_ok    = mapped && upper_zero && I_PADDR[1:0] == 2'h0;
	wire logic       access     = I_PSEL && I_PENABLE;

	// bypass lifts the lock on the buffer only
	wire logic       locked     = I_PROT_LOCK && drc_pkg::LOCKABLE[idx] &&
	                              !(idx == drc_pkg::IDX_BUF && outcfg_r.buffer_protect_bypass); // [RL4] [RL12]
	// 8-bit registers take lane 0 only
	wire logic       lane0      = I_PSTRB[0];
	wire logic [7:0] wd0        = I_PWDATA[7:0];

	// which writes go through the converter side
	wire logic       srst_wr_req = idx == drc_pkg::IDX_MAIN && lane0 && wd0[drc_pkg::MAIN_SRST];
	wire logic       en_wr_req   = idx == drc_pkg::IDX_MAIN && lane0 && wd0[drc_pkg::MAIN_EN] != enable_r;
	wire logic       data_wr_req = (idx == drc_pkg::IDX_SAMPLE || idx == drc_pkg::IDX_BUF) && I_PSTRB[1:0] != 2'h0;
	wire logic       needs_sync  = I_PWRITE && addr_ok && !locked && (srst_wr_req || en_wr_req || data_wr_req);

	// a second synchronised write waits on the bus rather than overtaking the first
	wire logic       stall       = access && needs_sync && pend_r;
	wire logic       done_acc    = access && !stall;

	// refused writes still complete, changing nothing
	wire logic       we          = done_acc && I_PWRITE && addr_ok && !locked; // [RL4]
	wire logic       we8         = we && lane0; // [RL1]

	// reads never wait
	assign O_PREADY  = !stall;
	assign O_PSLVERR = done_acc && (!addr_ok || (I_PWRITE && locked));

	//------------------------------------------------------------
	// write strobes per register
	//------------------------------------------------------------
	wire logic       wr_main   = we8 && idx == drc_pkg::IDX_MAIN;
	wire logic       wr_srst   = wr_main && wd0[drc_pkg::MAIN_SRST]; // [RL8]
	wire logic       wr_main_k = wr_main && !wd0[drc_pkg::MAIN_SRST] && !srst_r; // [RL9]
	wire logic       wr_outcfg = we8 && idx == drc_pkg::IDX_OUTCFG && !srst_r;
	wire logic       wr_evcfg  = we8 && idx == drc_pkg::IDX_EVCFG && !srst_r;

	// mask and flag writes act at once
	wire logic       wr_mclr   = we8 && idx == drc_pkg::IDX_MCLR;
	wire logic       wr_mset   = we8 && idx == drc_pkg::IDX_MSET;
	wire logic       wr_flags  = we8 && idx == drc_pkg::IDX_FLAGS;

	// either lane counts as a data write
	wire logic       wr_sample = we && idx == drc_pkg::IDX_SAMPLE && I_PSTRB[1:0] != 2'h0;
	wire logic       wr_buf    = we && idx == drc_pkg::IDX_BUF && I_PSTRB[1:0] != 2'h0;
	wire logic       sync_go   = we && needs_sync;

	//------------------------------------------------------------
	// synchronisation window and soft reset
	//------------------------------------------------------------
	// counter stands in for the cross-domain handshake
	wire logic       sync_end  = pend_r && sync_cnt_r == 8'h01;
	// one term returns every converter register to reset
	wire logic       soft_clr  = sync_end && srst_r; // [RL8] [RL10]

	// pending rises on the write and falls when the window closes
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pend_r       <= 1'b0;
			sync_cnt_r   <= 8'h00;
			cause_ctrl_r <= 1'b0;
		end else if (sync_go) begin
			pend_r       <= 1'b1; // [RL7]
			sync_cnt_r   <= 8'(drc_pkg::SYNC_CYCLES);
			cause_ctrl_r <= srst_wr_req || en_wr_req;
		end else if (pend_r) begin
			sync_cnt_r   <= sync_cnt_r - 8'h01;
			pend_r       <= !sync_end; // [RL10]
		end
	end

	// main control; standby bit acts at once, enable only at window end
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			srst_r   <= 1'b0;
			enable_r <= 1'b0;
			stby_r   <= 1'b0;
			en_eff_r <= 1'b0;
		end else if (soft_clr) begin
			srst_r   <= 1'b0; // [RL10]
			enable_r <= 1'b0;
			stby_r   <= 1'b0;
			en_eff_r <= 1'b0; // [RL8]
		end else begin
			if (wr_srst)
				srst_r <= 1'b1; // [RL9]
			if (wr_main_k) begin
				enable_r <= wd0[drc_pkg::MAIN_EN]; // [RL7]
				stby_r   <= wd0[drc_pkg::MAIN_STBY]; // [RL6]
			end
			// enable reaches the converter at window end
			if (sync_end)
				en_eff_r <= enable_r; // [RL7]
		end
	end

	// configuration registers; bit 5 of output_config is held at zero
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			outcfg_r <= drc_pkg::drc_outcfg_t'(drc_pkg::RST_8);
			evcfg_r  <= 2'h0;
		end else if (soft_clr) begin
			outcfg_r <= drc_pkg::drc_outcfg_t'(drc_pkg::RST_8);
			evcfg_r  <= 2'h0;
		end else begin
			if (wr_outcfg)
				outcfg_r <= drc_pkg::drc_outcfg_t'(wd0 & 8'hDF); // [RL3]
			// bits 7:2 are not stored
			if (wr_evcfg)
				evcfg_r <= wd0[1:0];
		end
	end

	//------------------------------------------------------------
	// interrupt masks and flags
	//------------------------------------------------------------
	wire logic       start_ok = I_START_EV && evcfg_r[drc_pkg::EV_START] && en_eff_r; // [RL18]
	// an empty buffer moves nothing, it only starves
	wire logic       xfer     = start_ok && !buf_empty_r;
	wire logic       starve   = start_ok && buf_empty_r; // [RL22]

	// enable or soft reset windows never raise sync-done
	wire logic       sync_ok  = sync_end && !cause_ctrl_r; // [RL23]
	wire logic [2:0] fl_set   = {sync_ok, xfer && !wr_buf, starve};
	wire logic [2:0] fl_clr   = ({3{wr_flags}} & wd0[2:0]) | {1'b0, wr_buf, 1'b0}; // [RL21]
	wire logic [2:0] mask_nxt = wr_mset ? (mask_r | wd0[2:0]) : // [RL20]
	                            wr_mclr ? (mask_r & ~wd0[2:0]) : mask_r; // [RL19]
	wire logic [2:0] flags_nxt = (flags_r & ~fl_clr) | fl_set;

	// one shared mask serves both set and clear views
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			mask_r  <= drc_pkg::RST_3;
			flags_r <= drc_pkg::RST_3;
		end else if (soft_clr) begin
			mask_r  <= drc_pkg::RST_3;
			flags_r <= drc_pkg::RST_3;
		end else begin
			mask_r  <= mask_nxt; // [RL25]
			flags_r <= flags_nxt; // hardware set wins over a clear
		end
	end

	assign O_IRQ = |(flags_r & mask_r); // [RL24]

	//------------------------------------------------------------
	// sample path: buffer, sample and converter code
	//------------------------------------------------------------
	wire logic [15:0] wd16       = I_PWDATA[15:0];
	wire logic [15:0] sample_nxt = wr_sample ? merge16(sample_r, wd16, I_PSTRB[1:0]) :
	                               xfer ? buf_r : sample_r; // [RL18]
	wire logic [15:0] buf_nxt    = wr_buf ? merge16(buf_r, wd16, I_PSTRB[1:0]) : buf_r;

	// a fresh buffer write beats a transfer in the same cycle
	wire logic        empty_nxt  = wr_buf ? 1'b0 : (xfer ? 1'b1 : buf_empty_r);

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sample_r    <= drc_pkg::RST_16;
			buf_r       <= drc_pkg::RST_16;
			buf_empty_r <= 1'b0;
		end else if (soft_clr) begin
			sample_r    <= drc_pkg::RST_16;
			buf_r       <= drc_pkg::RST_16;
			buf_empty_r <= 1'b0;
		end else begin
			sample_r    <= sample_nxt;
			buf_r       <= buf_nxt;
			buf_empty_r <= empty_nxt;
		end
	end

	// code reaches the converter on a transfer or when a data write settles
	wire logic       code_take = xfer || (sync_ok && !srst_r);
	wire logic [9:0] code_nxt  = xfer ? code_of(buf_r, outcfg_r.left_justify) :
	                             code_of(sample_r, outcfg_r.left_justify);

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			code_r     <= 10'h000;
			load_r     <= 1'b0;
			empty_ev_r <= 1'b0;
		end else begin
			code_r     <= soft_clr ? 10'h000 : (code_take ? code_nxt : code_r);
			// a soft reset swallows both pulses
			load_r     <= code_take && !soft_clr;
			empty_ev_r <= xfer && !wr_buf && !soft_clr && evcfg_r[drc_pkg::EV_EMPTY]; // [RL17]
		end
	end

	//------------------------------------------------------------
	// analog-side controls
	//------------------------------------------------------------
	assign O_CONV_EN    = en_eff_r;
	assign O_CONV_LOAD  = load_r;
	assign O_DAC_CODE   = code_r;
	assign O_EMPTY_EV   = empty_ev_r;
	// request stands until the buffer is refilled
	assign O_DMA_REQ    = buf_empty_r;
	// reserved code 3 passes through
	assign O_REF_SEL    = outcfg_r.ref_select; // [RL11]
	// high forces the pump off
	assign O_PUMP_OFF   = outcfg_r.pump_disable; // [RL13]
	assign O_INT_OUT_EN = outcfg_r.internal_out_en && en_eff_r; // [RL15]
	assign O_EXT_OUT_EN = outcfg_r.external_out_en && en_eff_r; // [RL16]
	// standby drops the pin buffer unless keep-in-standby is set
	assign O_OUT_BUF_ON = O_EXT_OUT_EN && (!I_STANDBY || stby_r); // [RL5]

	//------------------------------------------------------------
	// read mux; unlisted bits read zero
	//------------------------------------------------------------
	logic [15:0] rd_val;

	always_comb begin
		rd_val = 16'h0000;
		unique case (idx)
			drc_pkg::IDX_MAIN:   rd_val = {13'h0000, stby_r, enable_r, srst_r}; // [RL3]
			drc_pkg::IDX_OUTCFG: rd_val = {8'h00, outcfg_r};
			drc_pkg::IDX_EVCFG:  rd_val = {14'h0000, evcfg_r};
			drc_pkg::IDX_MCLR,
			drc_pkg::IDX_MSET:   rd_val = {13'h0000, mask_r}; // [RL25]
			drc_pkg::IDX_FLAGS:  rd_val = {13'h0000, flags_r};
			drc_pkg::IDX_SYNC:   rd_val = {8'h00, pend_r, 7'h00};
			drc_pkg::IDX_SAMPLE: rd_val = sample_r;
			drc_pkg::IDX_BUF:    rd_val = buf_r;
			default:             rd_val = 16'h0000;
		endcase
	end

	// idle bus reads zero
	assign O_PRDATA = (access && addr_ok && !I_PWRITE) ? {16'h0000, rd_val} : 32'h00000000;

endmodule : drc_top

`default_nettype wire

// >>> rtl/drc_pkg.sv
//------------------------------------------------------------
// shared constants and types of the converter register block
//------------------------------------------------------------
package drc_pkg;

	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_MAIN   = 4'h0;
	localparam logic [3:0] IDX_OUTCFG = 4'h1;
	localparam logic [3:0] IDX_EVCFG  = 4'h2;
	localparam logic [3:0] IDX_RSV3   = 4'h3;
	localparam logic [3:0] IDX_MCLR   = 4'h4;
	localparam logic [3:0] IDX_MSET   = 4'h5;
	localparam logic [3:0] IDX_FLAGS  = 4'h6;
	localparam logic [3:0] IDX_SYNC   = 4'h7;
	localparam logic [3:0] IDX_SAMPLE = 4'h8;
	localparam logic [3:0] IDX_BUF    = 4'hC;

	// per-index lock property: set where the access protector can block writes
	localparam logic [15:0] LOCKABLE  = 16'h1177;

	// main_control bit positions
	localparam int unsigned MAIN_SRST = 0;
	localparam int unsigned MAIN_EN   = 1;
	localparam int unsigned MAIN_STBY = 2;

	// event_config bit positions
	localparam int unsigned EV_START  = 0;
	localparam int unsigned EV_EMPTY  = 1;

	// irq flag / mask bit positions
	localparam int unsigned FLG_UNDER = 0;
	localparam int unsigned FLG_EMPTY = 1;
	localparam int unsigned FLG_SYNC  = 2;
	localparam int unsigned NUM_FLAGS = 3;

	// sync_state bit position
	localparam int unsigned SYNC_BIT  = 7;

	// reset values
	localparam logic [7:0]  RST_8     = 8'h00;
	localparam logic [15:0] RST_16    = 16'h0000;
	localparam logic [2:0]  RST_3     = 3'h0;

	// time the converter side needs to take over a synchronised write
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SYNC_TIME_NS  = 30;
	localparam int unsigned SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// reference choices
	typedef enum logic [1:0] {
		REF_INTERNAL_1V = 2'h0,
		REF_SUPPLY      = 2'h1,
		REF_EXTERNAL    = 2'h2,
		REF_RESERVED    = 2'h3
	} drc_ref_t;

	// output_config layout, msb first
	typedef struct packed {
		drc_ref_t ref_select;
		logic     reserved5;
		logic     buffer_protect_bypass;
		logic     pump_disable;
		logic     left_justify;
		logic     internal_out_en;
		logic     external_out_en;
	} drc_outcfg_t;

endpackage : drc_pkg

// >>> testbench/drc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// port-level checks of the register block
//------------------------------------------------------------
module drc_chk #(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              I_REF_CLK,
	input  wire logic              I_ARST_N,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       O_PRDATA,
	input  wire logic              O_PREADY,
	input  wire logic              O_PSLVERR,
	input  wire logic              I_PROT_LOCK,
	input  wire logic              I_STANDBY,
	input  wire logic              O_EMPTY_EV,
	input  wire logic              O_DMA_REQ,
	input  wire logic              O_IRQ,
	input  wire logic              O_CONV_EN,
	input  wire logic              O_INT_OUT_EN,
	input  wire logic              O_EXT_OUT_EN,
	input  wire logic              O_OUT_BUF_ON
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);

	// access decode; unmapped covers holes and stray address bits
	wire logic       acc = I_PSEL && I_PENABLE;
	wire logic       fin = acc && O_PREADY;
	wire logic [3:0] idx = I_PADDR[5:2];
	wire logic       unm = (I_PADDR[1:0] != 2'h0) || (I_PADDR[ADDR_W-1:6] != '0) || (idx == 4'h3)
		|| (idx > 4'h8 && idx != drc_pkg::IDX_BUF);

	a_stall_bound: assert property (acc && !O_PREADY |-> ##[1:4] O_PREADY)
		else $error("stalled access did not finish");
	a_read_nostall: assert property (acc && !I_PWRITE |-> O_PREADY)
		else $error("read was stalled");
	a_unmapped_err: assert property (fin && unm |-> O_PSLVERR && O_PRDATA == 32'h0)
		else $error("hole in map answered");
	a_reserved_zero: assert property (fin && !I_PWRITE && !unm
		|-> (idx < 4'h8) ? (O_PRDATA[31:8] == 24'h0) : (O_PRDATA[31:16] == 16'h0))
		else $error("unused read bits not zero");
	a_lock_refuse: assert property (fin && I_PWRITE && I_PROT_LOCK && drc_pkg::LOCKABLE[idx]
		&& idx != drc_pkg::IDX_BUF |-> O_PSLVERR) else $error("locked write accepted");
	a_ext_gate: assert property (O_EXT_OUT_EN |-> O_CONV_EN) else $error("pin driver on while off");
	a_int_gate: assert property (O_INT_OUT_EN |-> O_CONV_EN) else $error("comparator route on while off");
	a_buf_gate: assert property (O_OUT_BUF_ON |-> O_EXT_OUT_EN) else $error("buffer on without output");
	a_buf_awake: assert property (O_EXT_OUT_EN && !I_STANDBY |-> O_OUT_BUF_ON)
		else $error("buffer off while awake");
	a_empty_dma: assert property (O_EMPTY_EV |-> O_DMA_REQ) else $error("empty event without request");
	a_ev_needs_en: assert property ($rose(O_EMPTY_EV) |-> $past(O_CONV_EN) || $past(O_CONV_EN, 2))
		else $error("event acted while disabled");

	// main scenarios seen
	c_stall: cover property (acc && !O_PREADY);
	c_error: cover property (fin && O_PSLVERR);
	c_event: cover property (O_EMPTY_EV);
	c_irq: cover property (O_IRQ);
endmodule : drc_chk

bind drc_top drc_chk #(.ADDR_W(ADDR_W)) u_chk (
	.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.I_PROT_LOCK(I_PROT_LOCK), .I_STANDBY(I_STANDBY), .O_EMPTY_EV(O_EMPTY_EV), .O_DMA_REQ(O_DMA_REQ),
	.O_IRQ(O_IRQ), .O_CONV_EN(O_CONV_EN), .O_INT_OUT_EN(O_INT_OUT_EN), .O_EXT_OUT_EN(O_EXT_OUT_EN),
	.O_OUT_BUF_ON(O_OUT_BUF_ON)
);
`default_nettype wire

// >>> testbench/drc_apb_mst.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// processor side: one apb transfer at a time
//------------------------------------------------------------
module drc_apb_mst (
	input  wire logic        i_clk,
	input  wire logic        i_ready,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [7:0]       o_paddr,
	output logic [31:0]      o_pwdata,
	output logic [3:0]       o_pstrb,
	output logic             o_tmo
);
	// idle bus at time zero
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
		o_pstrb = 4'h0;
		o_tmo = 1'b0;
	end

	// request held until ready seen high; idle cycle between transfers keeps drives single
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
		int n;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= w ? dat : 32'h0;
		o_pstrb <= w ? s : 4'h0;
		@(posedge i_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ready !== 1'b1 && n < 20);
		if (i_ready !== 1'b1) o_tmo <= 1'b1;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask : xfer
endmodule : drc_apb_mst
`default_nettype wire

// >>> testbench/drc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drc_top_tb;
	logic        clk, arst_n, lock, stby, start_ev, tmo;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, lfsr;
	logic [3:0]  pstrb;
	logic        empty_ev, dma_req, irq, conv_en, pump_off, int_en, ext_en, buf_on, conv_load;
	logic [9:0]  dac_code;
	logic [1:0]  ref_sel;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          err_count, checked, ev_cnt, ld_cnt;

	// free-running clock, 10 ns
	always #5 clk = ~clk;

	drc_top u_dut (
		.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_PROT_LOCK(lock), .I_STANDBY(stby), .I_START_EV(start_ev),
		.O_EMPTY_EV(empty_ev), .O_DMA_REQ(dma_req), .O_IRQ(irq), .O_CONV_EN(conv_en), .O_CONV_LOAD(conv_load),
		.O_DAC_CODE(dac_code), .O_REF_SEL(ref_sel), .O_PUMP_OFF(pump_off), .O_INT_OUT_EN(int_en),
		.O_EXT_OUT_EN(ext_en), .O_OUT_BUF_ON(buf_on)
	);
	drc_apb_mst u_mst (
		.i_clk(clk), .i_ready(pready), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .o_tmo(tmo)
	);

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : cmp32
	task automatic cmp1(input logic g, input logic x);
		cmp32({31'h0, g}, {31'h0, x});
	endtask : cmp1
	task automatic finish_test;
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	// note expected answer, then run the transfer; reserved bits always written zero
	task automatic wr(input logic [3:0] i, input logic [15:0] v, input logic [3:0] s, input logic x);
		exp_q.push_back({x, 1'b0, 32'h0});
		u_mst.xfer(1'b1, {2'h0, i, 2'h0}, {16'h0, v}, s);
	endtask : wr
	task automatic rd(input logic [3:0] i, input logic [15:0] v, input logic x);
		exp_q.push_back({x, 1'b1, 16'h0, v});
		u_mst.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, 4'h0);
	endtask : rd
	task automatic pulse;
		start_ev <= 1'b1;
		@(posedge clk);
		start_ev <= 1'b0;
	endtask : pulse

	// monitor: each completed transfer takes the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) cmp1(1'b1, 1'b0);
			else begin
				e = exp_q.pop_front();
				cmp1(pslverr, e[33]);
				if (e[32]) cmp32(prdata, e[31:0]);
			end
		end
	end
	// count event and load pulses; a hung transfer ends the run
	always @(posedge clk) if (empty_ev === 1'b1) ev_cnt++;
	always @(posedge clk) if (conv_load === 1'b1) ld_cnt++;
	always @(posedge tmo) begin
		err_count++;
		finish_test();
	end

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		lock = 1'b0;
		stby = 1'b0;
		start_ev = 1'b0;
		lfsr = 32'h0001_5CBC;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (int k = 0; k < 13; k++) rd(k[3:0], 16'h0, k == 3 || (k > 8 && k < 12));
		for (int k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			wr(drc_pkg::IDX_OUTCFG, {8'h0, k[1:0], 1'b0, lfsr[4:0]}, 4'h1, 1'b0);
			rd(drc_pkg::IDX_OUTCFG, {8'h0, k[1:0], 1'b0, lfsr[4:0]}, 1'b0);
			cmp32({30'h0, ref_sel}, k);
			cmp1(pump_off, lfsr[3]);
		end
		wr(drc_pkg::IDX_OUTCFG, 16'h0001, 4'h1, 1'b0);
		wr(drc_pkg::IDX_MAIN, 16'h0006, 4'h1, 1'b0);
		rd(drc_pkg::IDX_SYNC, 16'h0080, 1'b0);
		rd(drc_pkg::IDX_MAIN, 16'h0006, 1'b0);
		rd(drc_pkg::IDX_FLAGS, 16'h0000, 1'b0);
		cmp1(conv_en, 1'b1);
		stby <= 1'b1;
		rd(drc_pkg::IDX_SYNC, 16'h0000, 1'b0);
		cmp1(buf_on, 1'b1);
		cmp1(ext_en, 1'b1);
		cmp1(int_en, 1'b0);
		wr(drc_pkg::IDX_MAIN, 16'h0002, 4'h1, 1'b0);
		rd(drc_pkg::IDX_SYNC, 16'h0000, 1'b0);
		cmp1(buf_on, 1'b0);
		stby <= 1'b0;
		wr(drc_pkg::IDX_MSET, 16'h0007, 4'h1, 1'b0);
		rd(drc_pkg::IDX_MCLR, 16'h0007, 1'b0);
		wr(drc_pkg::IDX_MCLR, 16'h0002, 4'h1, 1'b0);
		wr(drc_pkg::IDX_MSET, 16'h0000, 4'h1, 1'b0);
		rd(drc_pkg::IDX_MSET, 16'h0005, 1'b0);
		// sample placement both ways, sync-done interrupt raised and cleared
		for (int k = 0; k < 2; k++) begin
			lfsr = nxt(lfsr);
			wr(drc_pkg::IDX_OUTCFG, {13'h0, k[0], 2'h1}, 4'h1, 1'b0);
			wr(drc_pkg::IDX_SAMPLE, lfsr[15:0], 4'h3, 1'b0);
			repeat (4) @(posedge clk);
			rd(drc_pkg::IDX_SAMPLE, lfsr[15:0], 1'b0);
			rd(drc_pkg::IDX_FLAGS, 16'h0004, 1'b0);
			cmp32({22'h0, dac_code}, k[0] ? lfsr[15:6] : lfsr[9:0]);
			cmp1(irq, 1'b1);
			wr(drc_pkg::IDX_FLAGS, 16'h0004, 4'h1, 1'b0);
			rd(drc_pkg::IDX_FLAGS, 16'h0000, 1'b0);
			cmp1(irq, 1'b0);
		end
		// single lanes, second write stalls behind the first
		wr(drc_pkg::IDX_SAMPLE, 16'h005A, 4'h1, 1'b0);
		wr(drc_pkg::IDX_SAMPLE, 16'hA500, 4'h2, 1'b0);
		repeat (4) @(posedge clk);
		rd(drc_pkg::IDX_SAMPLE, {8'hA5, 8'h5A}, 1'b0);
		wr(drc_pkg::IDX_EVCFG, 16'h0003, 4'h1, 1'b0);
		lfsr = nxt(lfsr);
		wr(drc_pkg::IDX_BUF, lfsr[15:0], 4'h3, 1'b0);
		repeat (4) @(posedge clk);
		rd(drc_pkg::IDX_FLAGS, 16'h0004, 1'b0);
		pulse();
		rd(drc_pkg::IDX_SAMPLE, lfsr[15:0], 1'b0);
		rd(drc_pkg::IDX_FLAGS, 16'h0006, 1'b0);
		cmp1(dma_req, 1'b1);
		cmp32(ev_cnt, 32'h1);
		cmp32({22'h0, dac_code}, lfsr[15:6]);
		pulse();
		rd(drc_pkg::IDX_FLAGS, 16'h0007, 1'b0);
		wr(drc_pkg::IDX_BUF, 16'h0040, 4'h3, 1'b0);
		repeat (4) @(posedge clk);
		rd(drc_pkg::IDX_FLAGS, 16'h0005, 1'b0);
		cmp1(dma_req, 1'b0);
		wr(drc_pkg::IDX_FLAGS, 16'h0007, 4'h1, 1'b0);
		lock <= 1'b1;
		wr(drc_pkg::IDX_OUTCFG, 16'h0010, 4'h1, 1'b1);
		rd(drc_pkg::IDX_OUTCFG, 16'h0005, 1'b0);
		wr(drc_pkg::IDX_BUF, 16'h0123, 4'h3, 1'b1);
		lock <= 1'b0;
		wr(drc_pkg::IDX_OUTCFG, 16'h0015, 4'h1, 1'b0);
		lock <= 1'b1;
		wr(drc_pkg::IDX_BUF, 16'h0123, 4'h3, 1'b0);
		rd(drc_pkg::IDX_BUF, 16'h0123, 1'b0);
		lock <= 1'b0;
		repeat (4) @(posedge clk);
		wr(drc_pkg::IDX_MAIN, 16'h0007, 4'h1, 1'b0);
		rd(drc_pkg::IDX_SYNC, 16'h0080, 1'b0);
		repeat (4) @(posedge clk);
		rd(drc_pkg::IDX_MAIN, 16'h0000, 1'b0);
		rd(drc_pkg::IDX_OUTCFG, 16'h0000, 1'b0);
		rd(drc_pkg::IDX_MSET, 16'h0000, 1'b0);
		cmp1(conv_en, 1'b0);
		cmp32(ld_cnt, 32'h8);
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule : drc_top_tb
`default_nettype wire
